// ==== logic/debug_freeze_control.sv ====
// freeze assert/release register pair driving per-engine hold outputs
// Operation
// - a one at bit 0 of assert freezes the wake-up timer; zero ignored
// - a one at bit 1 of assert freezes the base soft timer; zero ignored
// - a one at bit 3 of assert freezes the system watchdog; zero ignored
// - system watchdog freeze acts only while its reset-instead-of-nmi setting is zero
// - a one at bit 5 of assert halts the dma engine; zero ignored
// - a one at bit 6 of assert freezes soft timer two; zero ignored
// - a one at bit 8 of assert freezes soft timer three; zero ignored
// - a one at bit 9 of assert freezes soft timer four; zero ignored
// - a one at bit 10 of assert freezes the radio engine watchdog
// - a one at bit 0 of release resumes the wake-up timer; zero ignored
// - a one at bit 1 of release resumes the base soft timer; zero ignored
// - a one at bit 3 of release resumes the system watchdog; zero ignored
// - a one at bit 5 of release resumes the dma engine; zero ignored
// - a one at bit 6 of release resumes soft timer two; zero ignored
// - a one at bit 8 of release resumes soft timer three; zero ignored
// - a one at bit 9 of release resumes soft timer four; zero ignored
// - a one at bit 10 of release resumes the radio engine watchdog
// - assert register sits at 0x50050300, release register at 0x50050304
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module debug_freeze_control
  import freeze_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_WDOG_NMI_RST,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_HOLD_WAKEUP_TIMER,
  output logic O_HOLD_SOFT_TIMER_BASE,
  output logic O_HOLD_SYSTEM_WATCHDOG,
  output logic O_HOLD_TRANSFER_ENGINE,
  output logic O_HOLD_SOFT_TIMER_TWO,
  output logic O_HOLD_SOFT_TIMER_THREE,
  output logic O_HOLD_SOFT_TIMER_FOUR,
  output logic O_HOLD_RADIO_ENGINE_WATCHDOG
);

  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic nmi_meta_reg;
  logic nmi_sync_reg;

  // only the defined target bits are storable; spare and reserved bits are dropped
  function automatic logic [HOLD_W-1:0] target_bits(input logic [DATA_W-1:0] data);
    return data[HOLD_W-1:0] & HOLD_MASK;
  endfunction

  // write decode; an address outside the pair never touches the state
  wire hit_assert = I_ADDR == FREEZE_ASSERT_ADDR;
  wire hit_release = I_ADDR == FREEZE_RELEASE_ADDR;
  wire wr_assert = I_WR && hit_assert;
  wire wr_release = I_WR && hit_release;
  wire [HOLD_W-1:0] set_bits = wr_assert ? target_bits(I_WDATA) : '0;
  wire [HOLD_W-1:0] clr_bits = wr_release ? target_bits(I_WDATA) : '0;

  // the bus carries one write per cycle, so the last write is the only one;
  // zeros leave bits untouched in both registers
  assign hold_next = (hold_reg | set_bits) & ~clr_bits;

  // both addresses return the same held state; reserved bits stay zero
  wire hit_read = hit_assert || hit_release;
  assign rdata_next = (I_RD && hit_read) ? {{(DATA_W-HOLD_W){1'b0}}, hold_reg} : '0;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      hold_reg <= HOLD_RESET;
      rdata_reg <= '0;
      nmi_meta_reg <= 1'b0;
      nmi_sync_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      rdata_reg <= rdata_next;
      nmi_meta_reg <= I_WDOG_NMI_RST;
      nmi_sync_reg <= nmi_meta_reg;
    end
  end
  // read data and hold outputs

  assign O_RDATA = rdata_reg;
  assign O_HOLD_WAKEUP_TIMER = hold_reg[BIT_WAKEUP];
  assign O_HOLD_SOFT_TIMER_BASE = hold_reg[BIT_SOFT_BASE];
  // watchdog set to reset mode ignores the freeze, a safety trade-off kept on purpose
  assign O_HOLD_SYSTEM_WATCHDOG = hold_reg[BIT_SYS_WDOG] & ~nmi_sync_reg;
  assign O_HOLD_TRANSFER_ENGINE = hold_reg[BIT_DMA];
  assign O_HOLD_SOFT_TIMER_TWO = hold_reg[BIT_SOFT_TWO];
  assign O_HOLD_SOFT_TIMER_THREE = hold_reg[BIT_SOFT_THREE];
  assign O_HOLD_SOFT_TIMER_FOUR = hold_reg[BIT_SOFT_FOUR];
  assign O_HOLD_RADIO_ENGINE_WATCHDOG = hold_reg[BIT_RADIO_WDOG];

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // wake-up timer: set, release, zero bits ignored on both registers
  chk_wakeup_set: assert property (
    wr_assert && I_WDATA[BIT_WAKEUP]
    |=> O_HOLD_WAKEUP_TIMER)
    else $error("wake-up hold not set");
  chk_wakeup_clr: assert property (
    wr_release && I_WDATA[BIT_WAKEUP]
    |=> !hold_reg[BIT_WAKEUP])
    else $error("wake-up hold not released");
  chk_wakeup_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_WAKEUP]
    |=> $stable(hold_reg[BIT_WAKEUP]))
    else $error("wake-up hold changed by zero assert bit");
  chk_wakeup_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_WAKEUP]
    |=> $stable(hold_reg[BIT_WAKEUP]))
    else $error("wake-up hold changed by zero release bit");
  chk_wakeup_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_WAKEUP]) && !hold_reg[BIT_WAKEUP]
    |=> !hold_reg[BIT_WAKEUP])
    else $error("wake-up hold rose without assert");

  // base soft timer
  chk_base_set: assert property (
    wr_assert && I_WDATA[BIT_SOFT_BASE]
    |=> O_HOLD_SOFT_TIMER_BASE)
    else $error("base timer hold not set");
  chk_base_clr: assert property (
    wr_release && I_WDATA[BIT_SOFT_BASE]
    |=> !hold_reg[BIT_SOFT_BASE])
    else $error("base timer hold not released");
  chk_base_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_SOFT_BASE]
    |=> $stable(hold_reg[BIT_SOFT_BASE]))
    else $error("base timer hold changed by zero assert bit");
  chk_base_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_SOFT_BASE]
    |=> $stable(hold_reg[BIT_SOFT_BASE]))
    else $error("base timer hold changed by zero release bit");
  chk_base_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_SOFT_BASE]) && !hold_reg[BIT_SOFT_BASE]
    |=> !hold_reg[BIT_SOFT_BASE])
    else $error("base timer hold rose without assert");

  // system watchdog; the stored bit is checked, the output also depends on the gate
  chk_wdog_set: assert property (
    wr_assert && I_WDATA[BIT_SYS_WDOG]
    |=> hold_reg[BIT_SYS_WDOG])
    else $error("watchdog hold not set");
  chk_wdog_clr: assert property (
    wr_release && I_WDATA[BIT_SYS_WDOG]
    |=> !hold_reg[BIT_SYS_WDOG])
    else $error("watchdog hold not released");
  chk_wdog_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_SYS_WDOG]
    |=> $stable(hold_reg[BIT_SYS_WDOG]))
    else $error("watchdog hold changed by zero assert bit");
  chk_wdog_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_SYS_WDOG]
    |=> $stable(hold_reg[BIT_SYS_WDOG]))
    else $error("watchdog hold changed by zero release bit");
  chk_wdog_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_SYS_WDOG]) && !hold_reg[BIT_SYS_WDOG]
    |=> !hold_reg[BIT_SYS_WDOG])
    else $error("watchdog hold rose without assert");

  // transfer engine
  chk_dma_set: assert property (
    wr_assert && I_WDATA[BIT_DMA]
    |=> O_HOLD_TRANSFER_ENGINE)
    else $error("dma hold not set");
  chk_dma_clr: assert property (
    wr_release && I_WDATA[BIT_DMA]
    |=> !O_HOLD_TRANSFER_ENGINE)
    else $error("dma hold not released");
  chk_dma_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_DMA]
    |=> $stable(hold_reg[BIT_DMA]))
    else $error("dma hold changed by zero assert bit");
  chk_dma_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_DMA]
    |=> $stable(hold_reg[BIT_DMA]))
    else $error("dma hold changed by zero release bit");
  chk_dma_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_DMA]) && !hold_reg[BIT_DMA]
    |=> !hold_reg[BIT_DMA])
    else $error("dma hold rose without assert");

  // soft timer two
  chk_two_set: assert property (
    wr_assert && I_WDATA[BIT_SOFT_TWO]
    |=> O_HOLD_SOFT_TIMER_TWO)
    else $error("timer two hold not set");
  chk_two_clr: assert property (
    wr_release && I_WDATA[BIT_SOFT_TWO]
    |=> !O_HOLD_SOFT_TIMER_TWO)
    else $error("timer two hold not released");
  chk_two_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_SOFT_TWO]
    |=> $stable(hold_reg[BIT_SOFT_TWO]))
    else $error("timer two hold changed by zero assert bit");
  chk_two_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_SOFT_TWO]
    |=> $stable(hold_reg[BIT_SOFT_TWO]))
    else $error("timer two hold changed by zero release bit");
  chk_two_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_SOFT_TWO]) && !hold_reg[BIT_SOFT_TWO]
    |=> !hold_reg[BIT_SOFT_TWO])
    else $error("timer two hold rose without assert");

  // soft timer three
  chk_three_set: assert property (
    wr_assert && I_WDATA[BIT_SOFT_THREE]
    |=> O_HOLD_SOFT_TIMER_THREE)
    else $error("timer three hold not set");
  chk_three_clr: assert property (
    wr_release && I_WDATA[BIT_SOFT_THREE]
    |=> !O_HOLD_SOFT_TIMER_THREE)
    else $error("timer three hold not released");
  chk_three_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_SOFT_THREE]
    |=> $stable(hold_reg[BIT_SOFT_THREE]))
    else $error("timer three hold changed by zero assert bit");
  chk_three_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_SOFT_THREE]
    |=> $stable(hold_reg[BIT_SOFT_THREE]))
    else $error("timer three hold changed by zero release bit");
  chk_three_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_SOFT_THREE]) && !hold_reg[BIT_SOFT_THREE]
    |=> !hold_reg[BIT_SOFT_THREE])
    else $error("timer three hold rose without assert");

  // soft timer four
  chk_four_set: assert property (
    wr_assert && I_WDATA[BIT_SOFT_FOUR]
    |=> O_HOLD_SOFT_TIMER_FOUR)
    else $error("timer four hold not set");
  chk_four_clr: assert property (
    wr_release && I_WDATA[BIT_SOFT_FOUR]
    |=> !O_HOLD_SOFT_TIMER_FOUR)
    else $error("timer four hold not released");
  chk_four_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_SOFT_FOUR]
    |=> $stable(hold_reg[BIT_SOFT_FOUR]))
    else $error("timer four hold changed by zero assert bit");
  chk_four_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_SOFT_FOUR]
    |=> $stable(hold_reg[BIT_SOFT_FOUR]))
    else $error("timer four hold changed by zero release bit");
  chk_four_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_SOFT_FOUR]) && !hold_reg[BIT_SOFT_FOUR]
    |=> !hold_reg[BIT_SOFT_FOUR])
    else $error("timer four hold rose without assert");

  // radio engine watchdog
  // no gate here: only the system watchdog has a reset-mode override
  chk_radio_set: assert property (
    wr_assert && I_WDATA[BIT_RADIO_WDOG]
    |=> O_HOLD_RADIO_ENGINE_WATCHDOG)
    else $error("radio watchdog hold not set");
  chk_radio_clr: assert property (
    wr_release && I_WDATA[BIT_RADIO_WDOG]
    |=> !O_HOLD_RADIO_ENGINE_WATCHDOG)
    else $error("radio watchdog hold not released");
  chk_radio_set_zero: assert property (
    wr_assert && !I_WDATA[BIT_RADIO_WDOG]
    |=> $stable(hold_reg[BIT_RADIO_WDOG]))
    else $error("radio watchdog hold changed by zero assert bit");
  chk_radio_clr_zero: assert property (
    wr_release && !I_WDATA[BIT_RADIO_WDOG]
    |=> $stable(hold_reg[BIT_RADIO_WDOG]))
    else $error("radio watchdog hold changed by zero release bit");
  chk_radio_no_rise: assert property (
    !(wr_assert && I_WDATA[BIT_RADIO_WDOG]) && !hold_reg[BIT_RADIO_WDOG]
    |=> !hold_reg[BIT_RADIO_WDOG])
    else $error("radio watchdog hold rose without assert");

  // watchdog gate: reset mode overrides any freeze
  // the gate lags the pin by the two sync stages, a user sees it late
  chk_wdog_gate: assert property (
    nmi_sync_reg
    |-> !O_HOLD_SYSTEM_WATCHDOG)
    else $error("watchdog frozen in reset mode");
  chk_wdog_pass: assert property (
    !nmi_sync_reg
    |-> O_HOLD_SYSTEM_WATCHDOG == hold_reg[BIT_SYS_WDOG])
    else $error("watchdog hold not passed in nmi mode");
  chk_nmi_sync: assert property (
    nmi_meta_reg != nmi_sync_reg
    |=> nmi_sync_reg == $past(nmi_meta_reg))
    else $error("watchdog mode sync stage skipped");

  // whole-register behaviour
  // one write per cycle, so set and clear never meet in the same edge
  chk_release_clr: assert property (
    wr_release
    |=> (hold_reg & $past(clr_bits)) == '0)
    else $error("release did not clear");
  chk_zero_keeps: assert property (
    I_WR && (hit_assert || hit_release) && I_WDATA == '0
    |=> $stable(hold_reg))
    else $error("zero write changed state");
  chk_idle_keeps: assert property (
    !I_WR
    |=> $stable(hold_reg))
    else $error("state changed without write");
  chk_spare_zero: assert property (
    hold_reg[BIT_SPARE] == 1'h0 && hold_reg[4] == 1'h0 && hold_reg[7] == 1'h0)
    else $error("reserved bit set");

  // read port; data stand for one cycle only, zero otherwise
  chk_read_back: assert property (
    I_RD && hit_read
    |=> O_RDATA == {{(DATA_W-HOLD_W){1'h0}}, $past(hold_reg)})
    else $error("read data wrong");
  chk_read_other: assert property (
    I_RD && !hit_read
    |=> O_RDATA == '0)
    else $error("read of other address not zero");
  chk_read_idle: assert property (
    !I_RD
    |=> O_RDATA == '0)
    else $error("read data outside read cycle");

  // reset is checked with the default disable switched off
  // a synchronous reset needs one edge, so the next cycle must be clean
  chk_reset_clear: assert property (disable iff (1'h0)
    I_RST
    |=> hold_reg == HOLD_RESET && O_RDATA == '0)
    else $error("reset did not clear state");

  // main scenarios
  cov_freeze_all: cover property (hold_reg == HOLD_MASK);
  cov_set_release: cover property (hold_reg[BIT_DMA] ##1 !hold_reg[BIT_DMA]);
  cov_wdog_gated: cover property (hold_reg[BIT_SYS_WDOG] && nmi_sync_reg);
  cov_read_back: cover property (I_RD && hit_read && hold_reg != '0);
  cov_spare_write: cover property (wr_assert && I_WDATA[BIT_SPARE]);

endmodule

// ==== logic/freeze_pkg.sv ====
// package: register map and field layout of the freeze control bank
package freeze_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] FREEZE_ASSERT_ADDR = 32'h5005_0300;
  localparam logic [31:0] FREEZE_RELEASE_ADDR = 32'h5005_0304;
  localparam logic [31:0] DEBUG_INFO_ADDR = 32'h5005_0308;
  localparam logic [31:0] SYSTEM_STATUS_ADDR = 32'h5005_030c;
  localparam logic [31:0] CPU_FLASH_CACHE_TAG_ADDR = 32'h5005_0314;
  localparam int BIT_WAKEUP = 0;
  localparam int BIT_SOFT_BASE = 1;
  localparam int BIT_SPARE = 2;
  localparam int BIT_SYS_WDOG = 3;
  localparam int BIT_DMA = 5;
  localparam int BIT_SOFT_TWO = 6;
  localparam int BIT_SOFT_THREE = 8;
  localparam int BIT_SOFT_FOUR = 9;
  localparam int BIT_RADIO_WDOG = 10;
  localparam int HOLD_W = 11;
  localparam logic [10:0] HOLD_MASK = 11'h76b;
  localparam logic [10:0] HOLD_RESET = 11'h000;
endpackage

// ==== sim/debug_freeze_control_bench.sv ====
// self-checking bench for the freeze assert/release register pair
`timescale 1ns/10ps
module debug_freeze_control_bench;
  import freeze_pkg::*;
  logic clk_sys = 0, rst = 1, wr = 0, rd = 0, nmi = 0, rd_d = 0;
  logic [31:0] addr = '0, wdata = '0, rdata, lf = 32'hc068, a;
  logic [7:0] hold;
  logic [10:0] st = '0;
  logic [39:0] q[$];
  int errors = 0, samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  debug_freeze_control debug_freeze_control_i (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_WDOG_NMI_RST(nmi), .O_RDATA(rdata),
    .O_HOLD_WAKEUP_TIMER(hold[0]), .O_HOLD_SOFT_TIMER_BASE(hold[1]),
    .O_HOLD_SYSTEM_WATCHDOG(hold[2]), .O_HOLD_TRANSFER_ENGINE(hold[3]),
    .O_HOLD_SOFT_TIMER_TWO(hold[4]), .O_HOLD_SOFT_TIMER_THREE(hold[5]),
    .O_HOLD_SOFT_TIMER_FOUR(hold[6]), .O_HOLD_RADIO_ENGINE_WATCHDOG(hold[7]));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic compare(input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic write(input logic [31:0] wa, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= wa;
    wdata <= d;
    wr <= 1'b1;
    if (wa == FREEZE_ASSERT_ADDR) st = st | (d[10:0] & HOLD_MASK);
    else if (wa == FREEZE_RELEASE_ADDR) st = st & ~(d[10:0] & HOLD_MASK);
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic read(input logic [31:0] ra);
    logic [7:0] h;
    h = {st[10], st[9], st[8], st[6], st[5], st[3] & ~nmi, st[1], st[0]};
    @(posedge clk_sys);
    addr <= ra;
    rd <= 1'b1;
    q.push_back({h, (ra == FREEZE_ASSERT_ADDR || ra == FREEZE_RELEASE_ADDR) ? {21'h0, st} : 32'h0});
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask
  // one note per read; data and holds are judged together when the read answer stands
  always @(posedge clk_sys) begin
    rd_d <= rd;
    if (rd_d && q.size() == 0) compare(40'h0, 40'h1);
    else if (rd_d) compare(q.pop_front(), {hold, rdata});
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    read(FREEZE_ASSERT_ADDR);
    read(FREEZE_RELEASE_ADDR);
    for (int i = 0; i < 400; i++) begin
      lf = step(lf);
      a = (lf[1:0] == 2'h3) ? (lf[2] ? DEBUG_INFO_ADDR : 32'h5005_0310) :
          (lf[0] ? FREEZE_RELEASE_ADDR : FREEZE_ASSERT_ADDR);
      // the watchdog gate is resynchronised, so it moves only with settle time before a read
      if (lf[5:3] == 3'h0) nmi <= lf[6];
      lf = step(lf);
      // random words carry spare and reserved bits too; these must read back zero
      write(a, lf);
      repeat (3) @(posedge clk_sys);
      lf = step(lf);
      read(lf[8] ? a : (lf[7] ? FREEZE_RELEASE_ADDR : FREEZE_ASSERT_ADDR));
    end
    repeat (3) @(posedge clk_sys);
    stop_test;
  end
endmodule
